/* rfcgc_pkg.sv */
// constants and types of the gated event counter
// Behaviour
// - control value 8h enables counting of sense pin edges under software gating
// - control value 0 disables the counter, which holds its value
// - four read commands each return one nibble of the count to memory and accumulator
// - every enable clears the count to zero before counting starts
// - timer mode 18h waits for timer enabled and its first clock falling edge
// - timer mode stops counting at once on second timer underflow
// - pin mode: sense pin gates, tone generator clock is counted
// - pin mode starts counting after the first sense pin rising edge
// - pin mode second rising edge stops counting and raises the halt-release request
// - request with interrupt enable set raises the interrupt request
// - request with halt-release enable sets start condition flag and releases halt
// - control value 28h enables the counter in pin-gated mode
// - 1Ah selects temperature network timer mode; 9 selects reference network software mode
// - a network-only control value stops the counter keeping the network active
// - mask 40h enables counter halt release; clear mask 40h clears the request
// - values 1h, 2h, 4h select one network; inactive network pins tri-state
// - with stop-on-overflow the counter halts on overflow and sets the flag
// - otherwise the flag is a seventeenth bit, toggling as the count wraps
package rfcgc_pkg;
    localparam int CNT_W = 16;
    localparam logic [7:0] CTL_EN_BIT = 8'h08;
    localparam logic [7:0] CTL_TMR_BIT = 8'h10;
    localparam logic [7:0] CTL_PIN_BIT = 8'h20;
    localparam logic [7:0] CTL_NET_MASK = 8'h07;
    localparam logic [7:0] HALT_MASK = 8'h40;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam int NET_W = 3;
    localparam int NIB_W = 4;

    typedef enum logic [3:0] {
        RFCGC_IDLE = 4'h1,
        RFCGC_ARM = 4'h2,
        RFCGC_RUN = 4'h4,
        RFCGC_DONE = 4'h8
    } rfcgc_state_t;
endpackage

/* rfcgc_edge_if.sv */
// synchronised pin edge events passed to the counter core
interface rfcgc_edge_if;
    logic sense_rise;
    logic sense_fall;
    logic tmr_fall;
    logic gen_rise;
    modport src (output sense_rise, output sense_fall, output tmr_fall, output gen_rise);
    modport dst (input sense_rise, input sense_fall, input tmr_fall, input gen_rise);
endinterface

/* rfcgc_edge_sync.sv */
// two-stage synchronisers and edge detectors for the asynchronous inputs
module rfcgc_edge_sync (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // raw asynchronous inputs
    input wire logic sense_pin_in,
    input wire logic tmr_clk_in,
    input wire logic gen_clk_in,
    // edge events
    rfcgc_edge_if.src edge_o
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [2:0] prev;
        logic sense_rise;
        logic sense_fall;
        logic tmr_fall;
        logic gen_rise;
    } rfcgc_sync_t;

    rfcgc_sync_t st_reg;
    rfcgc_sync_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.meta = {gen_clk_in, tmr_clk_in, sense_pin_in};
        // only the second stage reads the first
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
        st_next.sense_rise = st_reg.sync[0] & ~st_reg.prev[0];
        st_next.sense_fall = ~st_reg.sync[0] & st_reg.prev[0];
        st_next.tmr_fall = ~st_reg.sync[1] & st_reg.prev[1];
        st_next.gen_rise = st_reg.sync[2] & ~st_reg.prev[2];
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign edge_o.sense_rise = st_reg.sense_rise;
    assign edge_o.sense_fall = st_reg.sense_fall;
    assign edge_o.tmr_fall = st_reg.tmr_fall;
    assign edge_o.gen_rise = st_reg.gen_rise;
endmodule // rfcgc_edge_sync

/* rfcgc_counter.sv */
// gated 16-bit event counter of the resistance-to-frequency unit
module rfcgc_counter #(
    parameter bit STOP_ON_OVF = 1'b0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // converter control command
    input wire logic converter_control_cmd_in,
    input wire logic [7:0] control_value_in,
    // read commands
    input wire logic count_read_cmd_a_in,
    input wire logic count_read_cmd_b_in,
    input wire logic count_read_cmd_c_in,
    input wire logic count_read_cmd_d_in,
    input wire logic status_read_cmd_in,
    // halt-release control commands
    input wire logic halt_release_enable_cmd_in,
    input wire logic halt_request_clear_cmd_in,
    input wire logic [7:0] halt_mask_in,
    input wire logic counter_interrupt_enable_in,
    // timer and generator
    input wire logic second_timer_enabled_in,
    input wire logic second_timer_underflow_in,
    input wire logic second_timer_clk_in,
    input wire logic tone_generator_clock_in,
    // sense pin
    input wire logic oscillator_sense_pin_in,
    // network pins, two-signal form: drive value and output enable
    output logic [2:0] network_pin_out,
    output logic [2:0] network_pin_oe_out,
    // read data to memory and accumulator
    output logic read_valid_out,
    output logic [3:0] read_data_out,
    output logic [3:0] accumulator_reg_out,
    // status and halt-release
    output logic [15:0] count_out,
    output logic count_overflow_flag_out,
    output logic counting_out,
    output logic counter_halt_release_request_out,
    output logic counter_halt_release_enable_out,
    output logic counter_start_condition_flag_out,
    output logic halt_release_out,
    output logic interrupt_request_out
);
    // refused at elaboration: read decoding assumes four nibbles
    if (rfcgc_pkg::CNT_W != 16) begin : g_bad_width
        $error("counter width must be 16");
    end

    typedef struct packed {
        rfcgc_pkg::rfcgc_state_t state;
        logic run;
        logic [15:0] count;
        logic ovf;
        logic tmr_mode;
        logic pin_mode;
        logic [2:0] net;
        logic [2:0] pin_oe;
        logic req;
        logic hen;
        logic scf;
        logic halt_rel;
        logic irq;
        logic rd_valid;
        logic [3:0] rd_data;
        logic [3:0] acc;
    } rfcgc_core_t;

    rfcgc_core_t st_reg;
    rfcgc_core_t st_next;
    rfcgc_edge_if edges ();

    rfcgc_edge_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .sense_pin_in(oscillator_sense_pin_in),
        .tmr_clk_in(second_timer_clk_in),
        .gen_clk_in(tone_generator_clock_in),
        .edge_o(edges.src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // timer enable and underflow come from the same clock, no synchroniser; the timer clock is synchronised
    function automatic logic [3:0] rfcgc_nibble(input logic [15:0] v, input logic [1:0] i);
        rfcgc_nibble = v[i*4 +: 4];
    endfunction

    logic count_tick;
    logic [16:0] inc;
    logic set_req;

    always_comb begin
        count_tick = st_reg.pin_mode ? edges.gen_rise : edges.sense_rise;
        inc = {1'b0, st_reg.count} + 17'h00001;
        set_req = 1'b0;
        st_next = st_reg;
        st_next.rd_valid = 1'b0;
        st_next.halt_rel = 1'b0;

        case (st_reg.state)
            rfcgc_pkg::RFCGC_ARM: begin
                if (st_reg.tmr_mode) begin
                    if (second_timer_enabled_in && edges.tmr_fall) begin
                        st_next.state = rfcgc_pkg::RFCGC_RUN;
                    end
                end else if (edges.sense_rise) begin
                    st_next.state = rfcgc_pkg::RFCGC_RUN;
                end
            end
            rfcgc_pkg::RFCGC_RUN: begin
                if (st_reg.tmr_mode && second_timer_underflow_in) begin
                    st_next.state = rfcgc_pkg::RFCGC_DONE;
                end else if (st_reg.pin_mode && edges.sense_rise) begin
                    st_next.state = rfcgc_pkg::RFCGC_DONE;
                    set_req = 1'b1;
                end else if (count_tick) begin
                    st_next.count = inc[15:0];
                    if (inc[16]) begin
                        if (STOP_ON_OVF) begin
                            st_next.ovf = 1'b1;
                            st_next.count = st_reg.count;
                            st_next.state = rfcgc_pkg::RFCGC_DONE;
                        end else begin
                            st_next.ovf = ~st_reg.ovf;
                        end
                    end
                end
            end
            default: begin
            end
        endcase

        if (converter_control_cmd_in) begin
            // network select, one at a time
            st_next.net = control_value_in[2:0];
            st_next.pin_oe = (control_value_in[2:0] == 3'h1 || control_value_in[2:0] == 3'h2
                || control_value_in[2:0] == 3'h4) ? control_value_in[2:0] : 3'h0;
            st_next.tmr_mode = (control_value_in & rfcgc_pkg::CTL_TMR_BIT) != 8'h00;
            st_next.pin_mode = (control_value_in & rfcgc_pkg::CTL_PIN_BIT) != 8'h00;
            if ((control_value_in & rfcgc_pkg::CTL_EN_BIT) != 8'h00) begin
                st_next.count = rfcgc_pkg::CNT_RESET;
                st_next.ovf = 1'b0;
                // software mode runs at once; gated modes arm
                if ((control_value_in & (rfcgc_pkg::CTL_TMR_BIT | rfcgc_pkg::CTL_PIN_BIT))
                    != 8'h00) begin
                    st_next.state = rfcgc_pkg::RFCGC_ARM;
                end else begin
                    st_next.state = rfcgc_pkg::RFCGC_RUN;
                end
            end else begin
                st_next.state = rfcgc_pkg::RFCGC_IDLE;
            end
        end

        if (halt_release_enable_cmd_in) begin
            st_next.hen = (halt_mask_in & rfcgc_pkg::HALT_MASK) != 8'h00;
        end
        // clear request; a new request wins
        if (halt_request_clear_cmd_in && (halt_mask_in & rfcgc_pkg::HALT_MASK) != 8'h00) begin
            st_next.req = 1'b0;
            st_next.scf = 1'b0;
        end
        if (set_req) begin
            st_next.req = 1'b1;
            if (st_reg.hen) begin
                st_next.scf = 1'b1;
                st_next.halt_rel = 1'b1;
            end
        end
        st_next.irq = st_next.req & counter_interrupt_enable_in;
        // registered so the running flag leaves a flop, not a compare
        st_next.run = st_next.state == rfcgc_pkg::RFCGC_RUN;

        if (count_read_cmd_a_in) begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data = rfcgc_nibble(st_reg.count, 2'h0);
        end else if (count_read_cmd_b_in) begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data = rfcgc_nibble(st_reg.count, 2'h1);
        end else if (count_read_cmd_c_in) begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data = rfcgc_nibble(st_reg.count, 2'h2);
        end else if (count_read_cmd_d_in) begin
            st_next.rd_valid = 1'b1;
            st_next.rd_data = rfcgc_nibble(st_reg.count, 2'h3);
        end else if (status_read_cmd_in) begin
            // overflow in bit 2 so a bit test can branch on it
            st_next.rd_valid = 1'b1;
            st_next.rd_data = {1'b0, st_reg.ovf, 2'b00};
        end
        if (st_next.rd_valid) begin
            st_next.acc = st_next.rd_data;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
            st_reg.state <= rfcgc_pkg::RFCGC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register, except network_pin_out, which is tied low
    assign network_pin_out = 3'h0;
    assign network_pin_oe_out = st_reg.pin_oe;
    assign read_valid_out = st_reg.rd_valid;
    assign read_data_out = st_reg.rd_data;
    assign accumulator_reg_out = st_reg.acc;
    assign count_out = st_reg.count;
    assign count_overflow_flag_out = st_reg.ovf;
    assign counting_out = st_reg.run;
    assign counter_halt_release_request_out = st_reg.req;
    assign counter_halt_release_enable_out = st_reg.hen;
    assign counter_start_condition_flag_out = st_reg.scf;
    assign halt_release_out = st_reg.halt_rel;
    assign interrupt_request_out = st_reg.irq;
endmodule // rfcgc_counter

/* rfcgc_counter_chk.sv */
// assertions on the ports of the gated event counter
module rfcgc_counter_chk #(
    parameter bit STOP_ON_OVF = 1'b0
) (
    input wire logic core_clk_in, rst_in, converter_control_cmd_in, counter_interrupt_enable_in,
    input wire logic [7:0] control_value_in, halt_mask_in,
    input wire logic count_read_cmd_a_in, count_read_cmd_b_in, count_read_cmd_c_in,
    input wire logic count_read_cmd_d_in, status_read_cmd_in, halt_release_enable_cmd_in,
    input wire logic [2:0] network_pin_oe_out,
    input wire logic [3:0] read_data_out,
    input wire logic [15:0] count_out,
    input wire logic read_valid_out, count_overflow_flag_out, counting_out, halt_release_out,
    input wire logic counter_halt_release_request_out, counter_halt_release_enable_out,
    input wire logic counter_start_condition_flag_out, interrupt_request_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire ctl = converter_control_cmd_in;
    wire lo_rd = count_read_cmd_a_in | count_read_cmd_b_in | count_read_cmd_c_in;
    property p_sw_on; ctl && control_value_in == 8'h08 |=> counting_out && count_out == 16'h0000;
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("software enable gave no cleared run");
    property p_off; ctl && control_value_in == 8'h00 |=> !counting_out; endproperty
    a_off: assert property (p_off) else $error("zero control left counter running");
    property p_pin_arm; ctl && control_value_in == 8'h28 |=> !counting_out && count_out == 16'h0000;
    endproperty
    a_pin_arm: assert property (p_pin_arm) else $error("pin mode ran before gate");
    property p_net; ctl && control_value_in == 8'h01 |=> !counting_out && network_pin_oe_out == 3'h1;
    endproperty
    a_net: assert property (p_net) else $error("network-only value mishandled");
    property p_one_net; $onehot0(network_pin_oe_out); endproperty
    a_one_net: assert property (p_one_net) else $error("two networks driven");
    property p_rd_a; count_read_cmd_a_in |=> read_valid_out && read_data_out == $past(count_out[3:0]);
    endproperty
    a_rd_a: assert property (p_rd_a) else $error("low nibble read wrong");
    property p_rd_b; count_read_cmd_b_in && !count_read_cmd_a_in |=>
        read_valid_out && read_data_out == $past(count_out[7:4]); endproperty
    a_rd_b: assert property (p_rd_b) else $error("second nibble read wrong");
    property p_quiet; (count_read_cmd_a_in || status_read_cmd_in) && !counting_out && !ctl |=>
        $stable(count_out) && $stable(count_overflow_flag_out); endproperty
    a_quiet: assert property (p_quiet) else $error("read disturbed the count");
    property p_stat; status_read_cmd_in && !lo_rd && !count_read_cmd_d_in |=>
        read_data_out[2] == $past(count_overflow_flag_out); endproperty
    a_stat: assert property (p_stat) else $error("status read lost overflow");
    property p_hen; halt_release_enable_cmd_in |=> counter_halt_release_enable_out == $past(halt_mask_in[6]);
    endproperty
    a_hen: assert property (p_hen) else $error("release enable not taken");
    property p_rel; halt_release_out |-> counter_start_condition_flag_out &&
        counter_halt_release_request_out && $past(counter_halt_release_enable_out); endproperty
    a_rel: assert property (p_rel) else $error("release without request");
    property p_irq; (counter_halt_release_request_out && counter_interrupt_enable_in) [*2] |->
        interrupt_request_out; endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    c_run: cover property (counting_out ##1 !counting_out);
    c_rel: cover property (halt_release_out);
    c_irq: cover property (interrupt_request_out);
endmodule // rfcgc_counter_chk
bind rfcgc_counter rfcgc_counter_chk #(.STOP_ON_OVF(STOP_ON_OVF)) i_rfcgc_counter_chk (.*);

/* rfcgc_osc_model.sv */
// behavioural rc oscillator seen on the sense pin
module rfcgc_osc_model (
    input wire logic core_clk_in,
    input wire logic run_in,
    input wire logic [7:0] half_in,
    input wire logic [2:0] net_oe_in,
    output logic sense_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_reg = 8'h00;
    initial sense_out = 1'b0;
    // needs driven network
    // stops only when low, so no runt pulse reaches the counter
    always @(posedge core_clk_in) begin
        if ((run_in && |net_oe_in) || sense_out) begin
            cnt_reg <= (cnt_reg >= half_in) ? 8'h00 : cnt_reg + 8'h01;
            if (cnt_reg >= half_in) sense_out <= !sense_out;
        end
    end
endmodule // rfcgc_osc_model

/* tb_top.sv */
// self-checking bench of the gated event counter
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin miscompares++; \
    $display("FAIL %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] v; logic c; logic [2:0] o;} rfcgc_row_t;
    logic core_clk_in, rst_in, converter_control_cmd_in, count_read_cmd_a_in, count_read_cmd_b_in;
    logic count_read_cmd_c_in, count_read_cmd_d_in, status_read_cmd_in, halt_release_enable_cmd_in;
    logic halt_request_clear_cmd_in, counter_interrupt_enable_in, second_timer_enabled_in;
    logic second_timer_underflow_in, second_timer_clk_in, tone_generator_clock_in, gate, run, osc_s;
    logic oscillator_sense_pin_in, read_valid_out, count_overflow_flag_out, counting_out;
    logic counter_halt_release_request_out, counter_halt_release_enable_out;
    logic counter_start_condition_flag_out, halt_release_out, interrupt_request_out;
    logic [7:0] control_value_in, halt_mask_in;
    logic [2:0] network_pin_out, network_pin_oe_out;
    logic [3:0] read_data_out, accumulator_reg_out;
    logic [15:0] count_out, held;
    logic [1:0] gdiv = 2'h0;
    int miscompares = 0, comparisons = 0, rises = 0, rels = 0;
    rfcgc_row_t rows [8] = '{'{8'h01, 1'b0, 3'h1}, '{8'h02, 1'b0, 3'h2}, '{8'h04, 1'b0, 3'h4},
        '{8'h09, 1'b1, 3'h1}, '{8'h1A, 1'b0, 3'h2}, '{8'h28, 1'b0, 3'h0},
        '{8'h08, 1'b1, 3'h0}, '{8'h00, 1'b0, 3'h0}};
    rfcgc_counter i_rfcgc_counter (.*);
    rfcgc_osc_model i_rfcgc_osc_model (.core_clk_in(core_clk_in), .run_in(run), .half_in(8'h04),
        .net_oe_in(network_pin_oe_out), .sense_out(osc_s));
    assign oscillator_sense_pin_in = osc_s | gate;
    assign tone_generator_clock_in = gdiv[1];
    always @(posedge core_clk_in) gdiv <= gdiv + 2'h1;
    always @(posedge osc_s) rises++;
    always @(posedge core_clk_in) if (halt_release_out) rels++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic ctl(input logic [7:0] v);
        converter_control_cmd_in <= 1'b1;
        control_value_in <= v;
        cyc(1);
        converter_control_cmd_in <= 1'b0;
    endtask
    task automatic rd(input int k, input logic [3:0] ex);
        {count_read_cmd_a_in, count_read_cmd_b_in, count_read_cmd_c_in, count_read_cmd_d_in} <= 4'h8 >> k;
        cyc(1);
        {count_read_cmd_a_in, count_read_cmd_b_in, count_read_cmd_c_in, count_read_cmd_d_in} <= 4'h0;
        cyc(1);
        `CHK("read valid", 1'b1, read_valid_out)
        `CHK("read data", ex, read_data_out)
        cyc(1);
        `CHK("accumulator", ex, accumulator_reg_out)
    endtask
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = !core_clk_in;
    end
    initial begin
        cyc(5000);
        miscompares++;
        print_verdict();
    end
    initial begin
        {converter_control_cmd_in, count_read_cmd_a_in, count_read_cmd_b_in, count_read_cmd_c_in,
            count_read_cmd_d_in, status_read_cmd_in, halt_release_enable_cmd_in, gate, run,
            halt_request_clear_cmd_in, counter_interrupt_enable_in, second_timer_enabled_in,
            second_timer_underflow_in, control_value_in, halt_mask_in} = '0;
        second_timer_clk_in = 1'b1;
        rst_in = 1'b1;
        cyc(16);
        rst_in <= 1'b0;
        cyc(1);
        foreach (rows[i]) begin
            ctl(rows[i].v);
            cyc(2);
            `CHK("counting", rows[i].c, counting_out)
            `CHK("network enable", rows[i].o, network_pin_oe_out)
            `CHK("network drive", 3'h0, network_pin_out)
            `CHK("cleared count", 16'h0000, count_out)
        end
        $display("test table done");
        ctl(8'h09);
        run <= 1'b1;
        cyc(60);
        run <= 1'b0;
        cyc(20);
        `CHK("software count", rises[15:0], count_out)
        ctl(8'h01);
        rd(0, rises[3:0]);
        rd(1, rises[7:4]);
        rd(2, rises[11:8]);
        rd(3, rises[15:12]);
        status_read_cmd_in <= 1'b1;
        cyc(1);
        status_read_cmd_in <= 1'b0;
        cyc(1);
        `CHK("status data", 4'h0, read_data_out)
        cyc(1);
        `CHK("overflow", 1'b0, count_overflow_flag_out)
        `CHK("count after reads", rises[15:0], count_out)
        held = rises[15:0];
        run <= 1'b1;
        cyc(40);
        run <= 1'b0;
        cyc(20);
        `CHK("stopped count", held, count_out)
        ctl(8'h08);
        cyc(2);
        `CHK("re-enable clear", 16'h0000, count_out)
        $display("test software gating done");
        ctl(8'h1A);
        run <= 1'b1;
        cyc(30);
        second_timer_enabled_in <= 1'b1;
        cyc(30);
        `CHK("timer wait", 16'h0000, count_out)
        second_timer_clk_in <= 1'b0;
        cyc(50);
        second_timer_underflow_in <= 1'b1;
        cyc(1);
        second_timer_underflow_in <= 1'b0;
        cyc(6);
        held = count_out;
        cyc(40);
        run <= 1'b0;
        `CHK("timer ran", 1'b1, held != 16'h0000)
        `CHK("timer stop", held, count_out)
        $display("test timer gating done");
        halt_mask_in <= 8'h40;
        halt_release_enable_cmd_in <= 1'b1;
        counter_interrupt_enable_in <= 1'b1;
        cyc(1);
        halt_release_enable_cmd_in <= 1'b0;
        ctl(8'h28);
        cyc(30);
        `CHK("pin wait", 16'h0000, count_out)
        `CHK("release enable", 1'b1, counter_halt_release_enable_out)
        gate <= 1'b1;
        cyc(10);
        gate <= 1'b0;
        cyc(40);
        gate <= 1'b1;
        cyc(10);
        `CHK("gate stop", 1'b0, counting_out)
        `CHK("request", 1'b1, counter_halt_release_request_out)
        `CHK("start flag", 1'b1, counter_start_condition_flag_out)
        `CHK("interrupt", 1'b1, interrupt_request_out)
        `CHK("release pulses", 1, rels)
        held = count_out;
        cyc(20);
        `CHK("generator counted", 1'b1, held != 16'h0000)
        `CHK("pin held", held, count_out)
        halt_request_clear_cmd_in <= 1'b1;
        cyc(1);
        halt_request_clear_cmd_in <= 1'b0;
        gate <= 1'b0;
        cyc(3);
        `CHK("request clear", 1'b0, counter_halt_release_request_out)
        $display("test pin gating done");
        ctl(8'h08);
        rst_in <= 1'b1;
        cyc(2);
        `CHK("reset stops", 1'b0, counting_out)
        rst_in <= 1'b0;
        cyc(1);
        ctl(8'h08);
        cyc(1);
        `CHK("run after reset", 1'b1, counting_out)
        `CHK("count after reset", 16'h0000, count_out)
        $display("test reset done");
        print_verdict();
    end
endmodule // tb_top
